/* dstpm_pin_mux.sv */
// Pin sharing logic for DMA, serial port and PWM trigger pins
//
// How it works
// - DMA request pins reach the controller only when selected as cause.
// - Acknowledge pin drives acceptance only while its output is enabled.
// - With acknowledge output off, the pin is the general-purpose port bit.
// - Serial 0 transmit pin drives data when enabled, else port bit.
// - Trigger on serial 0 transmit pin usable only with port output off.
// - Serial 0 clock pin drives clock when enabled, else PWM output when that is enabled, else port bit.
// - PWM output on serial 0 clock pin drives only while enabled.
// - Receive pins, which carry triggers a and c, are sampled; no peripheral drives them.
// - Serial 1 transmit pin drives data only while enabled.
// - Trigger on serial 1 transmit pin needs port and data output off.
// - Port bit on serial 1 transmit pin acts only with data output off.
// - Peripheral output wins over port output on a shared pin.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

module dstpm_pin_mux (
	input  wire logic                         ref_clk_in,
	input  wire logic                         sys_rst_in,
	input  wire logic [dstpm_pkg::ADDR_W-1:0] avs_address_in,
	input  wire logic                         avs_read_in,
	input  wire logic                         avs_write_in,
	input  wire logic [31:0]                  avs_writedata_in,
	input  wire logic [3:0]                   avs_byteenable_in,
	output logic      [31:0]                  avs_readdata_out,
	output logic                              avs_waitrequest_out,
	input  wire logic [dstpm_pkg::NPIN-1:0]   pad_level_in,
	output dstpm_pkg::dstpm_pad_drv_s         pad_drv_out,
	input  dstpm_pkg::dstpm_periph_drv_s      periph_drv_in,
	output dstpm_pkg::dstpm_periph_rcv_s      periph_rcv_out
);

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0]                ctrl;
	logic [31:0]                port_dir;
	logic [31:0]                port_data;
	logic [31:0]                rd_data;
	logic                       ack;

	// ****************************************
	// Bus decode
	// ****************************************
	wire                        req       = avs_read_in | avs_write_in;
	wire                        take      = req & ~ack;
	wire                        hit_ctrl  = avs_address_in == dstpm_pkg::OFS_CTRL;
	wire                        hit_dir   = avs_address_in == dstpm_pkg::OFS_DIR;
	wire                        hit_data  = avs_address_in == dstpm_pkg::OFS_DATA;
	wire                        hit_stat  = avs_address_in == dstpm_pkg::OFS_STAT;
	wire                        wr_commit = avs_write_in & ack;
	wire [31:0]                 be_mask;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign be_mask[8*g +: 8] = {8{avs_byteenable_in[g]}};
		end
	endgenerate

	wire [31:0] wr_val = avs_writedata_in & be_mask;

	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [31:0] keep,
		input logic [31:0] mask
	);
		merge = ((old_v & ~keep) | new_v) & mask;
	endfunction : merge

	wire [31:0] next_ctrl = merge(ctrl, wr_val, be_mask,
		dstpm_pkg::CTRL_MASK);
	wire [31:0] next_dir  = merge(port_dir, wr_val, be_mask,
		dstpm_pkg::PORT_MASK);
	wire [31:0] next_data = merge(port_data, wr_val, be_mask,
		dstpm_pkg::PORT_MASK);

	// ****************************************
	// Control fields
	// ****************************************
	wire       dma_req_in_ch0_sel  = ctrl[dstpm_pkg::CTL_DMA_REQ_IN_CH0_SEL];
	wire       dma_req_in_ch1_sel  = ctrl[dstpm_pkg::CTL_DMA_REQ_IN_CH1_SEL];
	wire       dma_ack_out_ch0_en   = ctrl[dstpm_pkg::CTL_DMA_ACK_OUT_CH0_EN];
	wire       dma_ack_out_ch1_en   = ctrl[dstpm_pkg::CTL_DMA_ACK_OUT_CH1_EN];
	wire       s0_tx_en   = ctrl[dstpm_pkg::CTL_SER0_TX_EN];
	wire       s0_ck_en   = ctrl[dstpm_pkg::CTL_SER0_CK_EN];
	wire       pwm_out_en = ctrl[dstpm_pkg::CTL_PWM_OUT_EN];
	wire       s1_tx_en   = ctrl[dstpm_pkg::CTL_SER1_TX_EN];
	wire       s0_rx_en   = ctrl[dstpm_pkg::CTL_SER0_RX_EN];
	wire       s1_rx_en   = ctrl[dstpm_pkg::CTL_SER1_RX_EN];
	wire [3:0] trig_en    = ctrl[dstpm_pkg::CTL_TRIG_LSB +: 4];

	// ****************************************
	// Status and read mux
	// ****************************************
	wire [31:0] stat_oe   = {23'h000000, pad_drv_out.oe};
	wire [31:0] stat_word = (stat_oe << dstpm_pkg::STAT_OE_LSB)
		| {23'h000000, pad_level_in};
	wire [31:0] next_rd =
		hit_ctrl ? ctrl :
		hit_dir  ? port_dir :
		hit_data ? port_data :
		hit_stat ? stat_word : 32'h0000_0000;

	assign avs_waitrequest_out = take;
	assign avs_readdata_out    = rd_data;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ack     <= 1'b0;
			rd_data <= 32'h0000_0000;
		end else begin
			ack     <= take;
			rd_data <= take ? next_rd : rd_data;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ctrl      <= dstpm_pkg::RST_CTRL;
			port_dir  <= dstpm_pkg::RST_DIR;
			port_data <= dstpm_pkg::RST_DATA;
		end else if (wr_commit) begin
			ctrl      <= hit_ctrl ? next_ctrl : ctrl;
			port_dir  <= hit_dir  ? next_dir  : port_dir;
			port_data <= hit_data ? next_data : port_data;
		end
	end

	// ****************************************
	// Peripheral output selection
	// ****************************************
	wire [dstpm_pkg::NPIN-1:0] per_en;
	wire [dstpm_pkg::NPIN-1:0] per_val;
	wire                       ck_pin_val;

	assign ck_pin_val = s0_ck_en ? periph_drv_in.ser0_serial_clock
		: periph_drv_in.pwm_timer_out_d;

	assign per_en[dstpm_pkg::PIN_DMA_REQ_IN_CH0] = 1'b0;
	assign per_en[dstpm_pkg::PIN_DMA_REQ_IN_CH1] = 1'b0;
	assign per_en[dstpm_pkg::PIN_DMA_ACK_OUT_CH0] = dma_ack_out_ch0_en;
	assign per_en[dstpm_pkg::PIN_DMA_ACK_OUT_CH1] = dma_ack_out_ch1_en;
	assign per_en[dstpm_pkg::PIN_S0_RX] = 1'b0;
	assign per_en[dstpm_pkg::PIN_S0_TX] = s0_tx_en;
	assign per_en[dstpm_pkg::PIN_S0_CK] = s0_ck_en | pwm_out_en;
	assign per_en[dstpm_pkg::PIN_S1_RX] = 1'b0;
	assign per_en[dstpm_pkg::PIN_S1_TX] = s1_tx_en;

	assign per_val[dstpm_pkg::PIN_DMA_REQ_IN_CH0] = 1'b0;
	assign per_val[dstpm_pkg::PIN_DMA_REQ_IN_CH1] = 1'b0;
	assign per_val[dstpm_pkg::PIN_DMA_ACK_OUT_CH0] = periph_drv_in.dma_ack_out_ch0;
	assign per_val[dstpm_pkg::PIN_DMA_ACK_OUT_CH1] = periph_drv_in.dma_ack_out_ch1;
	assign per_val[dstpm_pkg::PIN_S0_RX] = 1'b0;
	assign per_val[dstpm_pkg::PIN_S0_TX] = periph_drv_in.ser0_tx_data;
	assign per_val[dstpm_pkg::PIN_S0_CK] = ck_pin_val;
	assign per_val[dstpm_pkg::PIN_S1_RX] = 1'b0;
	assign per_val[dstpm_pkg::PIN_S1_TX] = periph_drv_in.ser1_tx_data;

	// ****************************************
	// Per-pin output mux
	// ****************************************
	generate
		for (g = 0; g < dstpm_pkg::NPIN; g++) begin : g_pin
			assign pad_drv_out.oe[g] = per_en[g] | port_dir[g];
			assign pad_drv_out.level[g] = per_en[g] ? per_val[g]
				: port_data[g];
		end
	endgenerate

	// ****************************************
	// Inputs towards the peripherals
	// ****************************************
	wire port_s0_tx_off = ~port_dir[dstpm_pkg::PIN_S0_TX];
	wire port_s1_tx_off = ~port_dir[dstpm_pkg::PIN_S1_TX];

	assign periph_rcv_out.dma_req_in_ch0 =
		dma_req_in_ch0_sel & pad_level_in[dstpm_pkg::PIN_DMA_REQ_IN_CH0];
	assign periph_rcv_out.dma_req_in_ch1 =
		dma_req_in_ch1_sel & pad_level_in[dstpm_pkg::PIN_DMA_REQ_IN_CH1];
	assign periph_rcv_out.ser0_rx_data =
		~s0_rx_en | pad_level_in[dstpm_pkg::PIN_S0_RX];
	assign periph_rcv_out.ser1_rx_data =
		~s1_rx_en | pad_level_in[dstpm_pkg::PIN_S1_RX];
	assign periph_rcv_out.ser0_serial_clock =
		pad_level_in[dstpm_pkg::PIN_S0_CK];
	assign periph_rcv_out.pwm_ext_trigger_a =
		trig_en[0] & pad_level_in[dstpm_pkg::PIN_S0_RX];
	assign periph_rcv_out.pwm_ext_trigger_b = trig_en[1] & port_s0_tx_off
		& pad_level_in[dstpm_pkg::PIN_S0_TX];
	assign periph_rcv_out.pwm_ext_trigger_c =
		trig_en[2] & pad_level_in[dstpm_pkg::PIN_S1_RX];
	assign periph_rcv_out.pwm_ext_trigger_d = trig_en[3] & port_s1_tx_off
		& ~s1_tx_en & pad_level_in[dstpm_pkg::PIN_S1_TX];

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_req_first;
		req & ~ack;
	endsequence

	sequence s_req_done;
		req & ~avs_waitrequest_out;
	endsequence

	sequence s_ctrl_write;
		avs_write_in & hit_ctrl & ~avs_waitrequest_out
			& avs_byteenable_in[0];
	endsequence

	sequence s_ctrl_read;
		avs_read_in & hit_ctrl & ~avs_waitrequest_out;
	endsequence

	bus_answer_a: assert property (
		s_req_first |=> s_req_done)
		else $error("bus request not answered in one cycle");

	wait_first_a: assert property (
		s_req_first |-> avs_waitrequest_out)
		else $error("waitrequest low in first request cycle");

	read_data_a: assert property (
		s_ctrl_read |-> avs_readdata_out == ctrl)
		else $error("control read data wrong");

	ctrl_update_a: assert property (
		s_ctrl_write |=> ctrl[7:0] == $past(avs_writedata_in[7:0]))
		else $error("control write did not land");

	dreq_gate_a: assert property (
		periph_rcv_out.dma_req_in_ch0 |->
		dma_req_in_ch0_sel && pad_level_in[dstpm_pkg::PIN_DMA_REQ_IN_CH0])
		else $error("dma request passed while not selected");

	dreq_closed_a: assert property (
		!dma_req_in_ch1_sel |-> !periph_rcv_out.dma_req_in_ch1)
		else $error("dma request 1 passed while not selected");

	dack_drive_a: assert property (
		dma_ack_out_ch1_en |-> pad_drv_out.oe[dstpm_pkg::PIN_DMA_ACK_OUT_CH1] &&
		pad_drv_out.level[dstpm_pkg::PIN_DMA_ACK_OUT_CH1]
		== periph_drv_in.dma_ack_out_ch1)
		else $error("acknowledge pin not driven by channel");

	dma_ack_out_ch0_drive_a: assert property (
		dma_ack_out_ch0_en |-> pad_drv_out.oe[dstpm_pkg::PIN_DMA_ACK_OUT_CH0] &&
		pad_drv_out.level[dstpm_pkg::PIN_DMA_ACK_OUT_CH0]
		== periph_drv_in.dma_ack_out_ch0)
		else $error("acknowledge 0 pin not driven by channel");

	dack_port_a: assert property (
		!dma_ack_out_ch0_en |-> pad_drv_out.oe[dstpm_pkg::PIN_DMA_ACK_OUT_CH0]
		== port_dir[dstpm_pkg::PIN_DMA_ACK_OUT_CH0] &&
		pad_drv_out.level[dstpm_pkg::PIN_DMA_ACK_OUT_CH0]
		== port_data[dstpm_pkg::PIN_DMA_ACK_OUT_CH0])
		else $error("acknowledge pin not returned to port");

	dma_ack_out_ch1_port_a: assert property (
		!dma_ack_out_ch1_en |-> pad_drv_out.oe[dstpm_pkg::PIN_DMA_ACK_OUT_CH1]
		== port_dir[dstpm_pkg::PIN_DMA_ACK_OUT_CH1] &&
		pad_drv_out.level[dstpm_pkg::PIN_DMA_ACK_OUT_CH1]
		== port_data[dstpm_pkg::PIN_DMA_ACK_OUT_CH1])
		else $error("acknowledge 1 pin not returned to port");

	s0_tx_pin_a: assert property (
		s0_tx_en |-> pad_drv_out.oe[dstpm_pkg::PIN_S0_TX] &&
		pad_drv_out.level[dstpm_pkg::PIN_S0_TX]
		== periph_drv_in.ser0_tx_data)
		else $error("serial 0 transmit pin wrong");

	s0_tx_port_a: assert property (
		!s0_tx_en |-> pad_drv_out.oe[dstpm_pkg::PIN_S0_TX]
		== port_dir[dstpm_pkg::PIN_S0_TX] &&
		pad_drv_out.level[dstpm_pkg::PIN_S0_TX]
		== port_data[dstpm_pkg::PIN_S0_TX])
		else $error("serial 0 transmit pin not returned to port");

	trig_b_gate_a: assert property (
		periph_rcv_out.pwm_ext_trigger_b |->
		!port_dir[dstpm_pkg::PIN_S0_TX])
		else $error("trigger b passed with port output on");

	s0_ck_pin_a: assert property (
		s0_ck_en |-> pad_drv_out.level[dstpm_pkg::PIN_S0_CK]
		== periph_drv_in.ser0_serial_clock)
		else $error("serial 0 clock pin wrong");

	s0_ck_port_a: assert property (
		!s0_ck_en && !pwm_out_en |->
		pad_drv_out.oe[dstpm_pkg::PIN_S0_CK]
		== port_dir[dstpm_pkg::PIN_S0_CK] &&
		pad_drv_out.level[dstpm_pkg::PIN_S0_CK]
		== port_data[dstpm_pkg::PIN_S0_CK])
		else $error("serial 0 clock pin not returned to port");

	pwm_out_pin_a: assert property (
		pwm_out_en && !s0_ck_en |->
		pad_drv_out.oe[dstpm_pkg::PIN_S0_CK] &&
		pad_drv_out.level[dstpm_pkg::PIN_S0_CK]
		== periph_drv_in.pwm_timer_out_d)
		else $error("pwm output pin wrong");

	rx_free_a: assert property (
		s0_rx_en && !port_dir[dstpm_pkg::PIN_S0_RX] |->
		!pad_drv_out.oe[dstpm_pkg::PIN_S0_RX] &&
		periph_rcv_out.ser0_rx_data
		== pad_level_in[dstpm_pkg::PIN_S0_RX])
		else $error("receive pin driven or not sampled");

	s1_rx_free_a: assert property (
		s1_rx_en && !port_dir[dstpm_pkg::PIN_S1_RX] |->
		!pad_drv_out.oe[dstpm_pkg::PIN_S1_RX] &&
		periph_rcv_out.ser1_rx_data
		== pad_level_in[dstpm_pkg::PIN_S1_RX])
		else $error("receive 1 pin driven or not sampled");

	s1_tx_pin_a: assert property (
		!s1_tx_en && !port_dir[dstpm_pkg::PIN_S1_TX] |->
		!pad_drv_out.oe[dstpm_pkg::PIN_S1_TX])
		else $error("serial 1 transmit pin driven while off");

	trig_d_gate_a: assert property (
		periph_rcv_out.pwm_ext_trigger_d |->
		!s1_tx_en && !port_dir[dstpm_pkg::PIN_S1_TX])
		else $error("trigger d passed while pin is output");

	s1_port_bit_a: assert property (
		s1_tx_en |-> pad_drv_out.level[dstpm_pkg::PIN_S1_TX]
		== periph_drv_in.ser1_tx_data)
		else $error("port bit reached serial 1 transmit pin");

	port_yield_a: assert property (
		per_en[dstpm_pkg::PIN_S0_TX] && port_dir[dstpm_pkg::PIN_S0_TX]
		|-> pad_drv_out.level[dstpm_pkg::PIN_S0_TX]
		== per_val[dstpm_pkg::PIN_S0_TX])
		else $error("port won over peripheral output");

	port_fallback_a: assert property (
		$rose(port_dir[dstpm_pkg::PIN_DMA_REQ_IN_CH0]) |->
		pad_drv_out.oe[dstpm_pkg::PIN_DMA_REQ_IN_CH0])
		else $error("port direction not applied to pin");

endmodule : dstpm_pin_mux

/* dstpm_pkg.sv */
// Constants and carriers for the shared DMA, serial and trigger pin group
package dstpm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W      = 4;
	localparam logic [3:0]  OFS_CTRL    = 4'h0;
	localparam logic [3:0]  OFS_DIR     = 4'h4;
	localparam logic [3:0]  OFS_DATA    = 4'h8;
	localparam logic [3:0]  OFS_STAT    = 4'hc;
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [31:0] RST_DIR     = 32'h0000_0000;
	localparam logic [31:0] RST_DATA    = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK   = 32'h0000_3fff;
	localparam logic [31:0] PORT_MASK   = 32'h0000_01ff;
	localparam int          STAT_OE_LSB = 16;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTL_DMA_REQ_IN_CH0_SEL  = 0;
	localparam int CTL_DMA_REQ_IN_CH1_SEL  = 1;
	localparam int CTL_DMA_ACK_OUT_CH0_EN   = 2;
	localparam int CTL_DMA_ACK_OUT_CH1_EN   = 3;
	localparam int CTL_SER0_TX_EN = 4;
	localparam int CTL_SER0_CK_EN = 5;
	localparam int CTL_PWM_OUT_EN = 6;
	localparam int CTL_SER1_TX_EN = 7;
	localparam int CTL_SER0_RX_EN = 8;
	localparam int CTL_SER1_RX_EN = 9;
	localparam int CTL_TRIG_LSB   = 10;

	// ****************************************
	// Pin positions
	// ****************************************
	localparam int NPIN       = 9;
	localparam int PIN_DMA_REQ_IN_CH0  = 0;
	localparam int PIN_DMA_REQ_IN_CH1  = 1;
	localparam int PIN_DMA_ACK_OUT_CH0  = 2;
	localparam int PIN_DMA_ACK_OUT_CH1  = 3;
	localparam int PIN_S0_RX  = 4;
	localparam int PIN_S0_TX  = 5;
	localparam int PIN_S0_CK  = 6;
	localparam int PIN_S1_RX  = 7;
	localparam int PIN_S1_TX  = 8;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [NPIN-1:0] level;
		logic [NPIN-1:0] oe;
	} dstpm_pad_drv_s;

	typedef struct packed {
		logic dma_ack_out_ch0;
		logic dma_ack_out_ch1;
		logic ser0_tx_data;
		logic ser0_serial_clock;
		logic pwm_timer_out_d;
		logic ser1_tx_data;
	} dstpm_periph_drv_s;

	typedef struct packed {
		logic dma_req_in_ch0;
		logic dma_req_in_ch1;
		logic ser0_rx_data;
		logic ser1_rx_data;
		logic ser0_serial_clock;
		logic pwm_ext_trigger_a;
		logic pwm_ext_trigger_b;
		logic pwm_ext_trigger_c;
		logic pwm_ext_trigger_d;
	} dstpm_periph_rcv_s;

endpackage : dstpm_pkg

/* dstpm_board_model.sv */
// Board-side model of the signals on the shared pins
`timescale 1ns/1ps

module dstpm_board_model (
	input  wire logic                       ref_clk_in,
	input  wire logic                       sys_rst_in,
	input  dstpm_pkg::dstpm_pad_drv_s       pad_drv_in,
	input  wire logic [dstpm_pkg::NPIN-1:0] board_en_in,
	input  wire logic [dstpm_pkg::NPIN-1:0] board_val_in,
	output logic      [dstpm_pkg::NPIN-1:0] pad_level_out
);
	logic [dstpm_pkg::NPIN-1:0] flt;

	// Undriven line keeps changing
	always_ff @(posedge ref_clk_in) begin
		flt <= sys_rst_in ? '0 : ~flt;
	end

	// Device first, board only where enabled by the bench
	assign pad_level_out = (pad_drv_in.oe & pad_drv_in.level) |
		(~pad_drv_in.oe & board_en_in & board_val_in) |
		(~pad_drv_in.oe & ~board_en_in & flt);
endmodule : dstpm_board_model

/* dstpm_pin_mux_tb.sv */
// Self-checking bench for the shared DMA, serial and trigger pins
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
	error_cnt++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module dstpm_pin_mux_tb;
	localparam logic [3:0] A_CTL = dstpm_pkg::OFS_CTRL;
	localparam logic [3:0] A_DIR = dstpm_pkg::OFS_DIR;
	localparam logic [3:0] A_DAT = dstpm_pkg::OFS_DATA;
	localparam logic [3:0] A_STA = dstpm_pkg::OFS_STAT;

	logic        ref_clk;
	logic        sys_rst;
	logic [3:0]  addr;
	logic        rd_req;
	logic        wr_req;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic [31:0] rdata_q;
	logic        wreq;
	logic [8:0]  pad;
	logic [8:0]  ben;
	logic [8:0]  bval;
	logic [3:0]  trg;
	int          error_cnt;
	int          checks_done;
	int          pin_t [6] = '{2, 3, 5, 6, 6, 8};
	int          en_t [6]  = '{2, 3, 4, 5, 6, 7};
	dstpm_pkg::dstpm_pad_drv_s    drv;
	dstpm_pkg::dstpm_periph_drv_s pdrv;
	dstpm_pkg::dstpm_periph_rcv_s rcv;

	assign trg = {rcv.pwm_ext_trigger_a, rcv.pwm_ext_trigger_b,
		rcv.pwm_ext_trigger_c, rcv.pwm_ext_trigger_d};

	dstpm_pin_mux dstpm_pin_mux_i (
		.ref_clk_in          (ref_clk),
		.sys_rst_in          (sys_rst),
		.avs_address_in      (addr),
		.avs_read_in         (rd_req),
		.avs_write_in        (wr_req),
		.avs_writedata_in    (wdata),
		.avs_byteenable_in   (be),
		.avs_readdata_out    (rdata),
		.avs_waitrequest_out (wreq),
		.pad_level_in        (pad),
		.pad_drv_out         (drv),
		.periph_drv_in       (pdrv),
		.periph_rcv_out      (rcv)
	);

	dstpm_board_model dstpm_board_model_i (
		.ref_clk_in    (ref_clk),
		.sys_rst_in    (sys_rst),
		.pad_drv_in    (drv),
		.board_en_in   (ben),
		.board_val_in  (bval),
		.pad_level_out (pad)
	);

	// ****************************************
	// Bus and pin drivers
	// ****************************************
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] e);
		int n;
		n = 0;
		@(posedge ref_clk);
		wr_req <= w;
		rd_req <= ~w;
		addr   <= a;
		wdata  <= d;
		be     <= e;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		rdata_q = rdata;
		wr_req <= 1'b0;
		rd_req <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			$display("MISMATCH waitrequest exp 0 got %b", wreq);
		end
		#1;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] ex);
		bus(1'b0, a, 32'h0, 4'hf);
		`CHK("register", ex, rdata_q)
	endtask : rd_chk

	task automatic put(input logic [5:0] p, input logic [8:0] e,
		input logic [8:0] v);
		@(posedge ref_clk);
		pdrv <= dstpm_pkg::dstpm_periph_drv_s'(p);
		ben  <= e;
		bval <= v;
		#1;
	endtask : put

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		`CHK("reset oe", 9'h000, drv.oe)
		rd_chk(A_CTL, dstpm_pkg::RST_CTRL);
		rd_chk(A_DIR, dstpm_pkg::RST_DIR);
		rd_chk(A_DAT, dstpm_pkg::RST_DATA);
		wr(A_CTL, 32'hffff_ffff);
		rd_chk(A_CTL, dstpm_pkg::CTRL_MASK);
		wr(A_DIR, 32'hffff_ffff);
		rd_chk(A_DIR, dstpm_pkg::PORT_MASK);
		bus(1'b1, A_CTL, 32'h0, 4'h1);
		rd_chk(A_CTL, dstpm_pkg::CTRL_MASK & 32'hffff_ff00);
		wr(4'h2, 32'hffff_ffff);
		rd_chk(4'h2, 32'h0);
		wr(A_CTL, 32'h0);
		wr(A_DIR, 32'h0);
	endtask : t_regs

	task automatic t_out;
		for (int i = 0; i < 6; i++) begin
			wr(A_DIR, 32'h1 << pin_t[i]);
			wr(A_DAT, 32'h1 << pin_t[i]);
			put(6'h00, 9'h000, 9'h000);
			`CHK("port oe", 1'b1, drv.oe[pin_t[i]])
			`CHK("port lvl", 1'b1, drv.level[pin_t[i]])
			wr(A_CTL, 32'h1 << en_t[i]);
			put(6'h20 >> i, 9'h000, 9'h000);
			`CHK("per lvl", 1'b1, drv.level[pin_t[i]])
			put(~(6'h20 >> i), 9'h000, 9'h000);
			`CHK("per lvl", 1'b0, drv.level[pin_t[i]])
			wr(A_DIR, 32'h0);
			`CHK("per oe", 1'b1, drv.oe[pin_t[i]])
			wr(A_CTL, 32'h0);
			`CHK("off oe", 1'b0, drv.oe[pin_t[i]])
		end
		wr(A_CTL, 32'h60);
		put(6'h04, 9'h000, 9'h000);
		`CHK("clk lvl", 1'b1, drv.level[6])
		put(6'h02, 9'h000, 9'h000);
		`CHK("clk lvl", 1'b0, drv.level[6])
		wr(A_CTL, 32'h0);
	endtask : t_out

	task automatic t_in;
		put(6'h00, 9'h1b3, 9'h000);
		`CHK("idle rx", 2'b11, {rcv.ser0_rx_data, rcv.ser1_rx_data})
		put(6'h00, 9'h1b3, 9'h1ff);
		`CHK("req", 2'b00, {rcv.dma_req_in_ch0, rcv.dma_req_in_ch1})
		`CHK("trg", 4'h0, trg)
		wr(A_CTL, 32'h3f03);
		`CHK("req", 2'b11, {rcv.dma_req_in_ch0, rcv.dma_req_in_ch1})
		`CHK("rx", 2'b11, {rcv.ser0_rx_data, rcv.ser1_rx_data})
		`CHK("trg", 4'hf, trg)
		`CHK("in oe", 9'h000, drv.oe & 9'h1b3)
		put(6'h00, 9'h1b3, 9'h000);
		`CHK("req", 2'b00, {rcv.dma_req_in_ch0, rcv.dma_req_in_ch1})
		`CHK("rx", 2'b00, {rcv.ser0_rx_data, rcv.ser1_rx_data})
		`CHK("trg", 4'h0, trg)
		put(6'h3f, 9'h0b3, 9'h1ff);
		wr(A_CTL, 32'h3f83);
		`CHK("trg d", 1'b0, rcv.pwm_ext_trigger_d)
		`CHK("trg b", 1'b1, rcv.pwm_ext_trigger_b)
		put(6'h3f, 9'h0d3, 9'h1ff);
		wr(A_DIR, 32'h20);
		wr(A_DAT, 32'h20);
		`CHK("trg b", 1'b0, rcv.pwm_ext_trigger_b)
		`CHK("clk in", 1'b1, rcv.ser0_serial_clock)
		wr(A_CTL, 32'h0);
		wr(A_DIR, 32'h0);
		put(6'h00, 9'h000, 9'h000);
	endtask : t_in

	task automatic t_stat;
		wr(A_DIR, 32'h1ff);
		wr(A_DAT, 32'h0a5);
		rd_chk(A_STA, 32'h01ff_00a5);
		wr(A_DIR, 32'h0);
	endtask : t_stat

	task automatic close_out;
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		error_cnt = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		rd_req = 1'b0;
		wr_req = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		be = 4'hf;
		ben = 9'h000;
		bval = 9'h000;
		pdrv = '0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_out;
		t_in;
		t_stat;
		close_out;
	end

	initial begin
		#40000;
		error_cnt++;
		close_out;
	end
endmodule : dstpm_pin_mux_tb
